// *** cache_params.svh ***
`ifndef CACHE_PARAMS_SVH
`define CACHE_PARAMS_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define OFS_CTRL     16'h0000
`define OFS_WAYS     16'h0004
`define OFS_LSIZE    16'h0008
`define OFS_CLEN     16'h000c
`define OFS_STAT     16'h0010
`define REGION_REGS  2'b00
`define REGION_TAG   2'b01
`define REGION_DATA  2'b10

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define CTRL_INV_BIT 0
`define CTRL_RAM_BIT 1
`define RST_RAM_SEL  1'b1
`define RST_WAYS     2'h2
`define RST_LSIZE    2'h0
`define RST_CLEN     9'h1ff
`define REMAP_OTP    3'h1
`define REMAP_FLASH  3'h2
`define TAG_ZERO_BIT 23
`define LFSR_SEED    8'h01

// ----------------------------------------
// timing
// ----------------------------------------
`define CLAT_CYCLES  3'h4
`define TAG_LAST_ROW 9'h1ff

`endif

// *** cache_pkg.sv ***
package cache_pkg;
    typedef enum logic [2:0] {
        S_CLEAR,
        S_IDLE,
        S_LOOKUP,
        S_FILL,
        S_LATENCY,
        S_BYPASS
    } state_t;
    typedef logic [23:0] tag_t;
    typedef logic [1:0]  cfg_t;
endpackage

// *** tag_if.sv ***
`timescale 1ns/1ps
interface tag_if;
    import cache_pkg::*;
    logic [8:0]       rd_row;
    tag_t [3:0]       rd_tag;
    logic             wr_en;
    logic [1:0]       wr_bank;
    logic [8:0]       wr_row;
    tag_t             wr_data;
    logic             clr_start;
    logic             clr_busy;
    logic [10:0]      dbg_idx;
    tag_t             dbg_tag;
    logic [7:0]       lfsr;
    modport ctl   (output rd_row, wr_en, wr_bank, wr_row, wr_data, clr_start, dbg_idx,
                   input rd_tag, clr_busy, dbg_tag, lfsr);
    modport store (input rd_row, wr_en, wr_bank, wr_row, wr_data, clr_start, dbg_idx,
                   output rd_tag, clr_busy, dbg_tag, lfsr);
endinterface

// *** tag_store.sv ***
`timescale 1ns/1ps
`include "cache_params.svh"
module tag_store (
    // clock and reset
    input  logic  pclk,
    input  logic  presetn,
    // controller side
    tag_if.store  tif
);
    import cache_pkg::*;

    // ----------------------------------------
    // storage: four banks of 512 rows
    // ----------------------------------------
    tag_t       tag_mem [0:3][0:511];
    logic [8:0] clr_row_reg;
    logic       clr_busy_reg;
    logic [7:0] lfsr_reg;

    // all four banks cleared in parallel so the wipe takes 512 clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clr_busy_reg <= 1'b1;                       // see R17
            clr_row_reg  <= 9'h000;
        end else if (tif.clr_start) begin
            clr_busy_reg <= 1'b1;                       // see R01
            clr_row_reg  <= 9'h000;
        end else if (clr_busy_reg) begin
            clr_row_reg <= clr_row_reg + 9'h001;
            if (clr_row_reg == `TAG_LAST_ROW) begin
                clr_busy_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (clr_busy_reg) begin
            for (int b = 0; b < 4; b++) begin
                tag_mem[b][clr_row_reg] <= '0;          // see R19
            end
        end else if (tif.wr_en) begin
            tag_mem[tif.wr_bank][tif.wr_row] <= tif.wr_data;
        end
    end

    // free running so victim picks are not tied to the miss pattern
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr_reg <= `LFSR_SEED;
        end else begin
            lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]}; // see R22
        end
    end

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            tif.rd_tag[b] = tag_mem[b][tif.rd_row];
        end
    end

    assign tif.dbg_tag  = tag_mem[tif.dbg_idx[10:9]][tif.dbg_idx[8:0]];
    assign tif.clr_busy = clr_busy_reg;
    assign tif.lfsr     = lfsr_reg;
endmodule

// *** flash_read_cache_controller.sv ***
`timescale 1ns/1ps
`include "cache_params.svh"
// Summary of operation
// R01 - invalidate bit clears tags, stalls core
// R02 - line size 8, 16 or 32 bytes
// R03 - one, two or four ways at run time
// R04 - data 16 kB and tags fixed
// R05 - reads cached; writes never touch cache
// R06 - same-line hit fast, line change +1
// R07 - cache only for remap 1/2
// R08 - ram select zero forces full bypass
// R09 - length only for flash remap, 64k steps
// R10 - reconfiguration without stall or flush
// R11 - physical lines of eight bytes
// R12 - new line size applied on refill only
// R13 - tag word: zero, address, validity code
// R14 - four banks form four/two/one ways
// R15 - empty ways first, then random victim
// R16 - random victim for two and four ways
// R17 - hardware reset restores defaults, wipes tags
// R18 - fetch during wipe waits, then served
// R19 - soft reset wipes tags, keeps config
// R20 - tag and data stores readable on bus
// R21 - miss fetches aligned line, sets code
// R22 - lfsr advances every clock
module flash_read_cache_controller (
    // clock and reset
    input  logic        pclk,
    input  logic        presetn,
    // apb slave
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [15:0] paddr,
    input  logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    // system control
    input  logic        software_reset_line,
    input  logic [2:0]  boot_remap_select,
    // core fetch port
    input  logic        fetch_req,
    input  logic        fetch_write,
    input  logic [24:0] fetch_addr,
    output logic [31:0] fetch_rdata,
    output logic        fetch_ready,
    // flash controller
    output logic        flash_req,
    output logic [24:0] flash_addr,
    output logic [3:0]  flash_words,
    input  logic        flash_rvalid,
    input  logic [31:0] flash_rdata
);
    import cache_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [1:0] bank_of(input logic [1:0] way, input logic [24:0] a,
                                           input cfg_t wc);
        case (wc)
            2'h0:    bank_of = a[13:12];
            2'h1:    bank_of = {way[0], a[12]};
            default: bank_of = way;
        endcase
    endfunction

    function automatic logic [2:0] nways(input cfg_t wc);
        case (wc)
            2'h0:    nways = 3'h1;
            2'h1:    nways = 3'h2;
            default: nways = 3'h4;
        endcase
    endfunction

    function automatic logic [3:0] words_of(input cfg_t ls);
        case (ls)
            2'h0:    words_of = 4'h2;
            2'h1:    words_of = 4'h4;
            default: words_of = 4'h8;
        endcase
    endfunction

    function automatic logic [24:0] line_base(input logic [24:0] a, input cfg_t ls);
        case (ls)
            2'h0:    line_base = {a[24:3], 3'h0};
            2'h1:    line_base = {a[24:4], 4'h0};
            default: line_base = {a[24:5], 5'h00};
        endcase
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    tag_if       tif ();
    state_t      state_reg;
    logic [31:0] data_mem [0:4095];
    logic        ram_sel_reg;
    logic        inv_pending_reg;
    logic        inv_take_reg;
    cfg_t        ways_reg;
    cfg_t        lsize_reg;
    logic [8:0]  clen_reg;
    logic        clr_go_reg;
    logic [24:0] addr_reg;
    logic [24:0] last_line_reg;
    logic        last_ok_reg;
    logic [2:0]  cnt_reg;
    logic [2:0]  wait_reg;
    logic [1:0]  fill_bank_reg;
    logic [1:0]  fill_code_reg;
    logic        fetch_ready_reg;
    logic [31:0] fetch_rdata_reg;
    logic        flash_req_reg;
    logic [24:0] flash_addr_reg;
    logic [3:0]  flash_words_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic [31:0] prdata_reg;

    tag_store u_tags (
        .pclk    (pclk),
        .presetn (presetn),
        .tif     (tif.store)
    );

    // ----------------------------------------
    // lookup
    // ----------------------------------------
    logic [24:0] look_addr;
    logic        hit;
    logic [1:0]  hit_bank;
    logic [1:0]  victim_bank;
    logic        cacheable;
    logic        same_line;
    logic [31:0] hit_data;
    logic [24:0] fill_word;

    assign look_addr  = (state_reg == S_IDLE) ? fetch_addr : addr_reg;
    assign tif.rd_row = look_addr[11:3];                // see R14

    always_comb begin
        logic       empty_found;
        logic [1:0] empty_way;
        logic [1:0] b;
        logic [1:0] vway;
        tag_t       t;
        empty_found = 1'b0;
        empty_way   = 2'h0;
        b           = 2'h0;
        t           = '0;
        vway        = 2'h0;
        hit         = 1'b0;
        hit_bank    = 2'h0;
        for (int w = 0; w < 4; w++) begin
            if (w < nways(ways_reg)) begin              // see R03
                b = bank_of(w[1:0], look_addr, ways_reg);
                t = tif.rd_tag[b];
                if (t[1:0] != 2'h0 && t[22:2] == look_addr[24:4]) begin
                    hit      = 1'b1;                    // see R12
                    hit_bank = b;
                end else if (t[1:0] == 2'h0 && !empty_found) begin
                    empty_found = 1'b1;                 // see R15
                    empty_way   = w[1:0];
                end
            end
        end
        // a full set takes an lfsr victim; one way leaves no choice
        vway        = empty_found ? empty_way : (tif.lfsr[1:0] & 2'(nways(ways_reg) - 3'h1)); // see R16
        victim_bank = bank_of(vway, look_addr, ways_reg);
    end

    always_comb begin
        logic remap_ok;
        logic in_len;
        remap_ok  = (boot_remap_select == `REMAP_OTP) || (boot_remap_select == `REMAP_FLASH); // see R07
        in_len    = (boot_remap_select != `REMAP_FLASH) || (fetch_addr[24:16] <= clen_reg); // see R09
        cacheable = ram_sel_reg && remap_ok && in_len;  // see R08
    end

    assign same_line = last_ok_reg && (line_base(fetch_addr, lsize_reg) == last_line_reg);
    assign hit_data  = data_mem[{hit_bank, look_addr[11:2]}];
    assign fill_word = 25'(flash_addr_reg + {19'h0, cnt_reg, 2'h0});

    // ----------------------------------------
    // fill path
    // ----------------------------------------
    assign tif.wr_en     = (state_reg == S_FILL) && flash_rvalid && cnt_reg[0];
    assign tif.wr_bank   = fill_bank_reg;
    assign tif.wr_row    = fill_word[11:3];             // see R11
    assign tif.wr_data   = {1'b0, fill_word[24:4], fill_code_reg}; // see R13
    assign tif.clr_start = clr_go_reg;

    always_ff @(posedge pclk) begin
        if (state_reg == S_FILL && flash_rvalid) begin
            data_mem[{fill_bank_reg, fill_word[11:2]}] <= flash_rdata; // see R04
        end
    end

    // ----------------------------------------
    // control state machine
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg       <= S_CLEAR;                 // see R17
            clr_go_reg      <= 1'b0;
            inv_take_reg    <= 1'b0;
            addr_reg        <= '0;
            last_line_reg   <= '0;
            last_ok_reg     <= 1'b0;
            cnt_reg         <= 3'h0;
            wait_reg        <= 3'h0;
            fill_bank_reg   <= 2'h0;
            fill_code_reg   <= 2'h0;
            fetch_ready_reg <= 1'b0;
            fetch_rdata_reg <= '0;
            flash_req_reg   <= 1'b0;
            flash_addr_reg  <= '0;
            flash_words_reg <= 4'h0;
        end else begin
            fetch_ready_reg <= 1'b0;
            clr_go_reg      <= 1'b0;
            inv_take_reg    <= 1'b0;
            if (software_reset_line) begin
                // words still streaming from flash are dropped
                state_reg     <= S_CLEAR;               // see R19
                clr_go_reg    <= 1'b1;
                flash_req_reg <= 1'b0;
                last_ok_reg   <= 1'b0;
            end else begin
                case (state_reg)
                    S_CLEAR: begin
                        if (!clr_go_reg && !tif.clr_busy) begin
                            state_reg <= S_IDLE;        // see R18
                        end
                    end
                    S_IDLE: begin
                        if (inv_pending_reg) begin
                            inv_take_reg <= 1'b1;
                            clr_go_reg   <= 1'b1;       // see R01
                            last_ok_reg  <= 1'b0;
                            state_reg    <= S_CLEAR;
                        end else if (fetch_req && !fetch_ready_reg) begin
                            addr_reg <= fetch_addr;
                            if (fetch_write) begin
                                fetch_ready_reg <= 1'b1; // see R05
                            end else if (!cacheable) begin
                                flash_req_reg   <= 1'b1;
                                flash_addr_reg  <= {fetch_addr[24:2], 2'h0};
                                flash_words_reg <= 4'h1;
                                state_reg       <= S_BYPASS;
                            end else if (hit && same_line) begin
                                fetch_rdata_reg <= hit_data; // see R06
                                fetch_ready_reg <= 1'b1;
                            end else if (hit) begin
                                state_reg <= S_LOOKUP;  // see R06
                            end else begin
                                flash_req_reg   <= 1'b1;
                                flash_addr_reg  <= line_base(fetch_addr, lsize_reg); // see R21
                                flash_words_reg <= words_of(lsize_reg); // see R02
                                fill_bank_reg   <= victim_bank;
                                fill_code_reg   <= (lsize_reg == 2'h3) ? 2'h3 : 2'(lsize_reg + 2'h1);
                                cnt_reg         <= 3'h0;
                                state_reg       <= S_FILL;
                            end
                        end
                    end
                    S_LOOKUP: begin
                        fetch_rdata_reg <= hit_data;
                        fetch_ready_reg <= 1'b1;
                        last_line_reg   <= line_base(addr_reg, lsize_reg);
                        last_ok_reg     <= 1'b1;
                        state_reg       <= S_IDLE;
                    end
                    S_FILL: begin
                        if (flash_rvalid) begin
                            cnt_reg <= cnt_reg + 3'h1;
                            if (fill_word[24:2] == addr_reg[24:2]) begin
                                fetch_rdata_reg <= flash_rdata;
                            end
                            if ({1'b0, cnt_reg} == flash_words_reg - 4'h1) begin
                                flash_req_reg <= 1'b0;
                                wait_reg      <= 3'h0;
                                state_reg     <= S_LATENCY;
                            end
                        end
                    end
                    S_LATENCY: begin
                        wait_reg <= wait_reg + 3'h1;
                        if (wait_reg == `CLAT_CYCLES - 3'h1) begin
                            fetch_ready_reg <= 1'b1;    // see R06
                            last_line_reg   <= flash_addr_reg;
                            last_ok_reg     <= 1'b1;
                            state_reg       <= S_IDLE;
                        end
                    end
                    S_BYPASS: begin
                        if (flash_rvalid) begin
                            fetch_rdata_reg <= flash_rdata;
                            fetch_ready_reg <= 1'b1;
                            flash_req_reg   <= 1'b0;
                            state_reg       <= S_IDLE;
                        end
                    end
                    default: state_reg <= S_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    logic        acc;
    logic        wr_ok;
    logic        mapped;
    logic [31:0] rd_val;

    assign acc         = psel && penable && !pready_reg;
    assign wr_ok       = psel && penable && pready_reg && pwrite && !pslverr_reg;
    assign tif.dbg_idx = paddr[12:2];

    always_comb begin
        mapped = 1'b0;
        rd_val = '0;
        case (paddr[15:14])
            `REGION_REGS: begin
                mapped = 1'b1;
                case (paddr)
                    `OFS_CTRL:  rd_val = {30'h0, ram_sel_reg, inv_pending_reg || (state_reg == S_CLEAR)};
                    `OFS_WAYS:  rd_val = {30'h0, ways_reg};
                    `OFS_LSIZE: rd_val = {30'h0, lsize_reg};
                    `OFS_CLEN:  rd_val = {23'h0, clen_reg};
                    `OFS_STAT:  rd_val = {30'h0, state_reg == S_BYPASS, state_reg == S_CLEAR};
                    default:    mapped = 1'b0;
                endcase
            end
            `REGION_TAG: begin
                mapped = !pwrite && !paddr[13];
                rd_val = {8'h0, tif.dbg_tag};           // see R20
            end
            `REGION_DATA: begin
                mapped = !pwrite;
                rd_val = data_mem[paddr[13:2]];         // see R20
            end
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else begin
            pready_reg <= acc;
            if (acc) begin
                pslverr_reg <= !mapped;
                prdata_reg  <= (mapped && !pwrite) ? rd_val : 32'h0;
            end
        end
    end

    // configuration survives soft reset; only presetn restores it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_sel_reg     <= `RST_RAM_SEL;            // see R17
            inv_pending_reg <= 1'b0;
            ways_reg        <= `RST_WAYS;
            lsize_reg       <= `RST_LSIZE;
            clen_reg        <= `RST_CLEN;
        end else begin
            if (wr_ok && paddr == `OFS_CTRL && pwdata[`CTRL_INV_BIT]) begin
                inv_pending_reg <= 1'b1;
            end else if (inv_take_reg) begin
                inv_pending_reg <= 1'b0;
            end
            if (wr_ok) begin
                case (paddr)
                    `OFS_CTRL:  ram_sel_reg <= pwdata[`CTRL_RAM_BIT];
                    `OFS_WAYS:  ways_reg    <= pwdata[1:0]; // see R10
                    `OFS_LSIZE: lsize_reg   <= pwdata[1:0]; // see R10
                    `OFS_CLEN:  clen_reg    <= pwdata[8:0];
                    default:    ;
                endcase
            end
        end
    end

    assign prdata      = prdata_reg;
    assign pready      = pready_reg;
    assign pslverr     = pslverr_reg;
    assign fetch_rdata = fetch_rdata_reg;
    assign fetch_ready = fetch_ready_reg;
    assign flash_req   = flash_req_reg;
    assign flash_addr  = flash_addr_reg;
    assign flash_words = flash_words_reg;
endmodule

// *** flash_model.sv ***
`timescale 1ns/1ps
module flash_model (
    // clock and pacing
    input  logic        pclk,
    input  logic        slow,
    // burst request
    input  logic        flash_req,
    input  logic [24:0] flash_addr,
    input  logic [3:0]  flash_words,
    // returned words
    output logic        flash_rvalid,
    output logic [31:0] flash_rdata
);
    logic [24:0] base;
    logic [3:0]  cnt;
    int          k;
    // ----
    // burst engine
    // ----
    // data is a function of the address so the bench can predict it
    initial begin
        flash_rvalid = 1'b0;
        flash_rdata  = 32'h0;
        forever begin
            @(posedge pclk);
            if (flash_req === 1'b1) begin
                base = flash_addr;
                cnt  = flash_words;
                for (k = 0; k < cnt; k++) begin
                    repeat (slow ? 6 : 1) @(posedge pclk);
                    flash_rvalid <= 1'b1;
                    flash_rdata  <= {7'h15, base + 25'(k * 4)};
                    @(posedge pclk);
                    flash_rvalid <= 1'b0;
                    // stale data is inverted, never left looking valid
                    flash_rdata  <= ~flash_rdata;
                end
            end
        end
    end
endmodule

// *** flash_read_cache_controller_monitor.sv ***
`timescale 1ns/1ps
module flash_read_cache_controller_monitor (
    // clock and reset
    input logic        pclk,
    input logic        presetn,
    // apb
    input logic        psel,
    input logic        penable,
    input logic        pready,
    // fetch and flash
    input logic        software_reset_line,
    input logic        fetch_write,
    input logic        fetch_ready,
    input logic        flash_req,
    input logic [24:0] flash_addr,
    input logic [3:0]  flash_words,
    input logic        flash_rvalid
);
    logic [9:0] up_cnt;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // saturating count since reset bounds the tag wipe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_cnt <= 10'h0;
        end else if (up_cnt != 10'h3ff) begin
            up_cnt <= up_cnt + 10'h1;
        end
    end
    sequence apb_wait;
        psel && penable && !pready;
    endsequence
    sequence fill_end;
        flash_req && flash_rvalid && flash_words != 4'h1 ##1 !flash_req;
    endsequence
    AST_APB_ONE_WAIT: assert property (apb_wait |=> pready)
        else $error("apb answer late");
    AST_WRITE_NO_FLASH: assert property ($rose(flash_req) |-> !fetch_write)
        else $error("write reached flash");
    AST_WORDS_LEGAL: assert property (flash_req |-> flash_words inside {4'h1, 4'h2, 4'h4, 4'h8})
        else $error("bad burst length");
    AST_LINE_ALIGN: assert property (flash_req |-> (flash_addr & ({flash_words, 2'b00} - 25'h1)) == 25'h0)
        else $error("burst not aligned");
    AST_BYPASS_LAT: assert property (flash_req && flash_rvalid && flash_words == 4'h1 && !software_reset_line
                                     |=> fetch_ready)
        else $error("bypass answer late");
    AST_MISS_LAT: assert property (fill_end |-> (!fetch_ready) [*4] ##1 fetch_ready)
        else $error("miss latency wrong");
    AST_WIPE_HOLD: assert property (up_cnt < 10'h1f4 |-> !fetch_ready)
        else $error("fetch served in wipe");
    AST_SOFT_HOLD: assert property (software_reset_line |-> ##2 (!fetch_ready) [*8])
        else $error("fetch served after soft reset");
endmodule

bind flash_read_cache_controller flash_read_cache_controller_monitor mon (
    .pclk, .presetn, .psel, .penable, .pready, .software_reset_line, .fetch_write,
    .fetch_ready, .flash_req, .flash_addr, .flash_words, .flash_rvalid
);

// *** flash_read_cache_controller_tb.sv ***
`timescale 1ns/1ps
module flash_read_cache_controller_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
    logic        software_reset_line, fetch_req, fetch_write, fetch_ready, flash_req, flash_rvalid;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, fetch_rdata, flash_rdata, rd;
    logic [24:0] fetch_addr, flash_addr, fa;
    logic [3:0]  flash_words, nw;
    logic [2:0]  boot_remap_select;
    logic [31:0] regv [5] = '{32'h2, 32'h2, 32'h0, 32'h1ff, 32'h0};
    int          n_fail, checked, lat, tail;
    flash_read_cache_controller dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .software_reset_line, .boot_remap_select, .fetch_req, .fetch_write, .fetch_addr,
        .fetch_rdata, .fetch_ready, .flash_req, .flash_addr, .flash_words, .flash_rvalid, .flash_rdata
    );
    flash_model far (.pclk, .slow, .flash_req, .flash_addr, .flash_words, .flash_rvalid, .flash_rdata);
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // ----
    // tasks
    // ----
    task automatic stop_test();
        if (n_fail == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic fetch(input logic [24:0] a, input logic w);
        lat         = 0;
        tail        = 0;
        nw          = 4'h0;
        fetch_req   <= 1'b1;
        fetch_addr  <= a;
        fetch_write <= w;
        do begin
            @(posedge pclk);
            lat++;
            tail = flash_rvalid ? 0 : tail + 1;
            if (flash_req === 1'b1) begin
                nw = flash_words;
                fa = flash_addr;
            end
        end while (fetch_ready !== 1'b1 && lat < 3000);
        rd        = fetch_rdata;
        fetch_req <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic hit(input logic [24:0] a, input int l);
        fetch(a, 1'b0);
        chk("hit_flash", 32'h0, {28'h0, nw});
        chk("hit_data", {7'h15, a[24:2], 2'b00}, rd);
        if (l > 0) chk("hit_wait", l, lat);
    endtask
    task automatic miss(input logic [24:0] a, input logic [3:0] w, input int t);
        fetch(a, 1'b0);
        chk("miss_words", {28'h0, w}, {28'h0, nw});
        chk("miss_addr", {7'h0, a & ~({w, 2'b00} - 25'h1)}, {7'h0, fa});
        chk("miss_data", {7'h15, a[24:2], 2'b00}, rd);
        chk("miss_tail", t, tail);
    endtask
    // ----
    // watchdog and tests
    // ----
    initial begin
        #400000;
        n_fail++;
        stop_test();
    end
    initial begin
        n_fail = 0; checked = 0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 16'h0; pwdata = 32'h0; software_reset_line = 1'b0; boot_remap_select = 3'h2;
        fetch_req = 1'b0; fetch_write = 1'b0; fetch_addr = 25'h0; slow = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        miss(25'h100, 4'h2, 5);
        chk("wipe_wait", 32'h1, {31'h0, lat > 512});
        foreach (regv[i]) begin
            apb(1'b0, 16'(i * 4), 32'h0);
            chk("reg_reset", regv[i], rd);
        end
        apb(1'b0, 16'h0020, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        apb(1'b1, 16'h4000, 32'hffff_ffff);
        chk("tag_write", 32'h1, {31'h0, err});
        apb(1'b0, 16'h4000, 32'h0);
        chk("tag_top", 32'h0, {31'h0, rd[23] | err});
        hit(25'h104, 2);
        miss(25'h108, 4'h2, 5);
        hit(25'h100, 3);
        apb(1'b1, 16'h0008, 32'h1);
        hit(25'h108, 0);
        miss(25'h118, 4'h4, 5);
        apb(1'b1, 16'h0008, 32'h2);
        hit(25'h11c, 0);
        miss(25'h134, 4'h8, 5);
        slow <= 1'b1;
        miss(25'h200c, 4'h8, 5);
        slow <= 1'b0;
        fetch(25'h104, 1'b1);
        chk("write_flash", 32'h0, {28'h0, nw});
        for (int w = 0; w < 3; w++) begin
            apb(1'b1, 16'h0004, 32'(w));
            apb(1'b0, 16'h0004, 32'h0);
            chk("ways", 32'(w), rd);
        end
        apb(1'b1, 16'h0000, 32'h0);
        miss(25'h104, 4'h1, 1);
        apb(1'b1, 16'h0000, 32'h2);
        boot_remap_select <= 3'h3;
        miss(25'h104, 4'h1, 1);
        boot_remap_select <= 3'h2;
        apb(1'b1, 16'h000c, 32'h0);
        miss(25'h10000, 4'h1, 1);
        hit(25'h104, 0);
        boot_remap_select <= 3'h1;
        miss(25'h30004, 4'h8, 5);
        apb(1'b1, 16'h0000, 32'h3);
        miss(25'h104, 4'h8, 5);
        software_reset_line <= 1'b1;
        @(posedge pclk);
        software_reset_line <= 1'b0;
        apb(1'b0, 16'h0010, 32'h0);
        chk("soft_wipe", 32'h1, {31'h0, rd[0]});
        apb(1'b0, 16'h000c, 32'h0);
        chk("soft_keep", 32'h0, rd);
        miss(25'h104, 4'h8, 5);
        stop_test();
    end
endmodule
